/* core/segmented_dac_input_decoder.sv */
// Purpose: Digital front end of a 12-bit segmented current-steering converter
// Assumes: One sample clock, source synchronous to it; format and power-down are slow straps
// Notes:   Latch, format conversion, segment decode, complementary drive registers
`timescale 1ns/1ps

// Notes on behaviour
// - Bit 11 most significant, bit 0 least
// - Full word captured each rising edge
// - Format low binary, high two's complement
// - Power-down input forces low-power idle state
// - Binary all-ones primary, all-zeros complementary
// - Top five bits: 31-segment thermometer
// - Next four bits: 15 sixteenth-weight sources
// - Low bits pass through binary weighted
// - Each source steered to exactly one output
// - One sample per clock, no stalls
// - Zero current on idle output extremes
// - Code 0..4095, complement is 4095 minus
module segmented_dac_input_decoder (
  input  wire logic                                 sys_clk_in,            // Sample clock
  input  wire logic                                 rst_b_in,              // Async reset, low
  input  wire logic                                 sample_bit_top,        // Most significant bit
  input  wire logic [dac_decode_pkg::SAMPLE_W-3:0]  sample_bits_middle,    // Bits 10 down to 1
  input  wire logic                                 sample_bit_bottom,     // Least significant bit
  input  wire logic                                 format_twos_in,        // High: two's complement
  input  wire logic                                 power_down_in,         // High: low-power state
  output dac_decode_pkg::switch_drive_t             switch_drive_out,      // Switch controls
  output logic      [dac_decode_pkg::SAMPLE_W-1:0]  dac_code_out,          // Effective code
  output logic      [dac_decode_pkg::SAMPLE_W-1:0]  complement_code_out,   // 4095 minus code
  output logic                                      powered_down_out       // Low-power state
);
  //////////////////////////////////////////////////////////////////////////////
  // Timing overview
  //////////////////////////////////////////////////////////////////////////////

  // Edge 1: the pin word lands in the input latch.
  // Edge 2: format, decode and drive registers take the new code.
  // Mode and power-down pins need one more edge: two synchroniser stages, then the drive registers.
  // No valid or ready: every edge carries a sample, back to back.
  // Hazard: the data pins have no synchroniser, so the source must be
  // timed to this clock; a stale or skewed word is latched as it stands.

  //////////////////////////////////////////////////////////////////////////////
  // Functions
  //////////////////////////////////////////////////////////////////////////////

  // Convert a captured word to the unsigned code
  // Sign flip only; the lower eleven bits keep their weight
  function automatic logic [dac_decode_pkg::SAMPLE_W-1:0] to_code(
    input logic [dac_decode_pkg::SAMPLE_W-1:0] word,
    input logic                                twos);
    logic [dac_decode_pkg::SAMPLE_W-1:0] res;
    res = word;
    if (twos) begin
      res[dac_decode_pkg::MSB_POS] = ~word[dac_decode_pkg::MSB_POS];
    end
    return res;
  endfunction

  // Weighted sum of a switch set in low-bit units
  // Used only by the checks below, never in the data path
  function automatic int weight_of(input dac_decode_pkg::switch_set_t s);
    int w;
    w = $countones(s.top_on) * dac_decode_pkg::MID_PER_TOP * dac_decode_pkg::LOW_PER_MID
      + $countones(s.mid_on) * dac_decode_pkg::LOW_PER_MID
      + int'(s.low_on);
    return w;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for static straps
  //////////////////////////////////////////////////////////////////////////////

  logic [1:0] fmt_sync_reg;   // Format select, two stages
  logic [1:0] pd_sync_reg;    // Power-down, two stages

  // Format pin: a slow strap, not timed to the sample clock.
  // Two stages keep a metastable first flop away from the decode.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fmt_sync_reg <= 2'h0;  // Straight binary out of reset
    end else begin
      fmt_sync_reg <= {fmt_sync_reg[0], format_twos_in};
    end
  end

  // Power-down pin: same two-stage treatment as the format pin.
  // Limitation: a pulse shorter than a clock may be missed.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pd_sync_reg <= 2'h0;  // Awake out of reset
    end else begin
      pd_sync_reg <= {pd_sync_reg[0], power_down_in};
    end
  end

  logic fmt_twos;   // Synchronised format
  logic pd_active;  // Synchronised power-down
  assign fmt_twos  = fmt_sync_reg[1];
  assign pd_active = pd_sync_reg[1];

  //////////////////////////////////////////////////////////////////////////////
  // Input latch
  //////////////////////////////////////////////////////////////////////////////

  logic [dac_decode_pkg::SAMPLE_W-1:0] pin_word;   // Assembled pin word
  logic [dac_decode_pkg::SAMPLE_W-1:0] held_word;  // Latched word

  // Top pin is the MSB, bottom pin the LSB
  assign pin_word = {sample_bit_top, sample_bits_middle, sample_bit_bottom};

  // Own module, so the capture stage can sit next to the pins
  sample_latch u_latch (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .word_in    (pin_word),
    .word_out   (held_word)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Format conversion and segment decode
  //////////////////////////////////////////////////////////////////////////////

  logic [dac_decode_pkg::SAMPLE_W-1:0] code_next;  // Unsigned code
  assign code_next = to_code(held_word, fmt_twos);

  // Segmentation of the 12-bit code, heaviest field first:
  //   top field     five bits, 31 equal segments
  //   middle field  four bits, 15 sources, each a sixteenth of a top one
  //   low field     three bits, binary fractions of one middle source
  // Thermometer fields cost more switches but keep each step monotonic.
  logic [dac_decode_pkg::TOP_SEGS-1:0] top_therm;  // Top segment enables
  logic [dac_decode_pkg::MID_SEGS-1:0] mid_therm;  // Middle source enables
  logic [dac_decode_pkg::LOW_W-1:0]    low_bits;   // Binary-weighted enables
  dac_decode_pkg::switch_set_t         set_next;   // Decoded primary controls

  // One carrier for the three fields
  assign set_next = '{top_on: top_therm, mid_on: mid_therm, low_on: low_bits};

  // Top field into 31 equal segments
  therm_decoder #(
    .IN_W (dac_decode_pkg::TOP_W),
    .SEGS (dac_decode_pkg::TOP_SEGS)
  ) u_top (
    .value_in  (code_next[dac_decode_pkg::TOP_LSB +: dac_decode_pkg::TOP_W]),
    .therm_out (top_therm)
  );

  // Middle field into 15 sixteenth-weight sources
  therm_decoder #(
    .IN_W (dac_decode_pkg::MID_W),
    .SEGS (dac_decode_pkg::MID_SEGS)
  ) u_mid (
    .value_in  (code_next[dac_decode_pkg::MID_LSB +: dac_decode_pkg::MID_W]),
    .therm_out (mid_therm)
  );

  // Low bits go straight to binary-weighted sources
  // No decode here: three binary switches are cheaper than seven unit ones
  assign low_bits = code_next[dac_decode_pkg::LOW_W-1:0];

  //////////////////////////////////////////////////////////////////////////////
  // Output drive registers
  //////////////////////////////////////////////////////////////////////////////

  localparam logic [dac_decode_pkg::SAMPLE_W-1:0] FULL_WORD =
    dac_decode_pkg::SAMPLE_W'(dac_decode_pkg::FULL_SCALE);  // All-ones code

  dac_decode_pkg::switch_set_t         set_reg;        // Registered primary set
  dac_decode_pkg::switch_set_t         comp_set_reg;   // Registered complementary set
  logic [dac_decode_pkg::SAMPLE_W-1:0] code_reg;       // Registered code
  logic [dac_decode_pkg::SAMPLE_W-1:0] comp_code_reg;  // Registered complement code
  logic                                pd_reg;         // Registered power state

  // Primary set: a fresh decode every clock, no stall.
  // Power-down parks it at zero rather than a third switch state.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      set_reg <= '0;
    end else if (pd_active) begin
      set_reg <= '0;
    end else begin
      set_reg <= set_next;
    end
  end

  // Complementary set: own flops, so both switch inputs launch on one edge.
  // Both come from one next value, so no source sits on both or neither.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      comp_set_reg <= '1;
    end else if (pd_active) begin
      comp_set_reg <= '1;
    end else begin
      comp_set_reg <= ~set_next;
    end
  end

  // Effective code, reported alongside the switch controls
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      code_reg <= dac_decode_pkg::ZERO_WORD;
    end else if (pd_active) begin
      code_reg <= dac_decode_pkg::ZERO_WORD;
    end else begin
      code_reg <= code_next;
    end
  end

  // Complement code: registered so the output leaves a flop, not a subtractor
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      comp_code_reg <= FULL_WORD;
    end else if (pd_active) begin
      comp_code_reg <= FULL_WORD;
    end else begin
      comp_code_reg <= FULL_WORD - code_next;
    end
  end

  // Power state flag, in step with the parked drive
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pd_reg <= 1'b0;
    end else begin
      pd_reg <= pd_active;
    end
  end

  // Outputs straight from the registers above
  assign switch_drive_out    = '{to_primary: set_reg, to_complement: comp_set_reg};
  assign dac_code_out        = code_reg;
  assign complement_code_out = comp_code_reg;
  assign powered_down_out    = pd_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  //////////////////////////////////////////////////////////////////////////////

  // Each check reads the registered outputs one edge after their cause.
  // Power-down cycles are excluded where the drive is parked on purpose.

  a_drive_complementary: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (switch_drive_out.to_primary ^ switch_drive_out.to_complement) == '1)
    else $error("switch drive not complementary");

  a_weight_matches_code: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    weight_of(switch_drive_out.to_primary) == int'(dac_code_out))
    else $error("primary weight differs from code");

  a_top_thermometer: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    $countones(set_reg.top_on) == int'(code_reg[dac_decode_pkg::TOP_LSB +: dac_decode_pkg::TOP_W]))
    else $error("top segment count wrong");

  a_mid_thermometer: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    $countones(set_reg.mid_on) == int'(code_reg[dac_decode_pkg::MID_LSB +: dac_decode_pkg::MID_W]))
    else $error("middle segment count wrong");

  a_pipe_latency: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    !pd_active |=> code_reg == to_code($past(held_word), $past(fmt_twos)))
    else $error("code does not follow latched word");

  a_binary_full: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (!fmt_twos && !pd_active && held_word == 12'hfff) |=> switch_drive_out.to_complement == '0)
    else $error("all ones not fully primary");

  a_binary_zero: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (!fmt_twos && !pd_active && held_word == 12'h000) |=> switch_drive_out.to_primary == '0)
    else $error("all zeros leaves primary current");

  a_twos_msb_flip: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (fmt_twos && !pd_active) |=> code_reg[dac_decode_pkg::MSB_POS] != $past(held_word[dac_decode_pkg::MSB_POS]))
    else $error("sign bit not inverted");

  a_power_down: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    pd_active |=> powered_down_out && switch_drive_out.to_primary == '0)
    else $error("power-down not applied");

  a_park_complement: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    pd_active |=> switch_drive_out.to_complement == '1 && complement_code_out == '1)
    else $error("power-down not parked on complementary side");

  a_low_passthrough: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    set_reg.low_on == code_reg[dac_decode_pkg::LOW_W-1:0])
    else $error("binary low bits differ from code");

  a_weight_complement: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    weight_of(switch_drive_out.to_complement) == int'(complement_code_out))
    else $error("complementary weight differs from code");

  a_codes_sum: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    int'(dac_code_out) + int'(complement_code_out) == dac_decode_pkg::FULL_SCALE)
    else $error("codes do not sum to full scale");

  // Main scenarios: two's complement format, both extremes, a sleep and a wake
  c_twos_mode: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in) fmt_twos && !pd_reg);
  c_full_scale: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in) dac_code_out == 12'hfff);
  c_sleep_wake: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in) pd_reg ##1 !pd_reg);
  c_zero_scale: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in) dac_code_out == '0 && !pd_reg);
  c_power_down: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in) pd_active ##1 pd_reg);
endmodule // segmented_dac_input_decoder

/* pkg/dac_decode_pkg.sv */
// Purpose: Shared widths, field positions and carrier types for the DAC input decoder
// Assumes: 12-bit sample word, 5/4/3 segmentation
// Notes:   Every sample width and field position used by the core lives here; its checks also use literal words such as 12'hfff
package dac_decode_pkg;
  localparam int SAMPLE_W     = 12;  // Sample word width
  localparam int TOP_W        = 5;   // Thermometer-coded top field
  localparam int MID_W        = 4;   // Thermometer-coded middle field
  localparam int LOW_W        = 3;   // Binary-weighted low field
  localparam int TOP_SEGS     = 31;  // Equal top segments
  localparam int MID_SEGS     = 15;  // Equal middle segments
  localparam int TOP_LSB      = 7;   // Position of top field
  localparam int MID_LSB      = 3;   // Position of middle field
  localparam int MSB_POS      = 11;  // Sign / most significant bit
  localparam int FULL_SCALE   = 4095;  // Largest unsigned code
  localparam int MID_PER_TOP  = 16;  // Middle weight per top segment
  localparam int LOW_PER_MID  = 8;   // Low weight per middle segment
  localparam real MAX_RATE_MSPS = 165.0;  // Highest sample rate
  localparam logic [SAMPLE_W-1:0] ZERO_WORD = 12'h000;  // Idle word

  // One complete set of switch controls
  typedef struct packed {
    logic [TOP_SEGS-1:0] top_on;   // Top segments to primary
    logic [MID_SEGS-1:0] mid_on;   // Middle segments to primary
    logic [LOW_W-1:0]    low_on;   // Binary bits to primary
  } switch_set_t;

  // Drive pair toward primary and complementary outputs
  typedef struct packed {
    switch_set_t to_primary;       // Set means source on primary
    switch_set_t to_complement;    // Set means source on complementary
  } switch_drive_t;
endpackage

/* core/sample_latch.sv */
// Purpose: Edge-triggered latch of the parallel sample word
// Assumes: Source meets setup/hold around rising edge
// Notes:   Single capture stage, no extra pipeline
`timescale 1ns/1ps
module sample_latch (
  input  wire logic                                  sys_clk_in,   // Sample clock
  input  wire logic                                  rst_b_in,     // Async reset, low
  input  wire logic [dac_decode_pkg::SAMPLE_W-1:0]   word_in,      // Word from pins
  output logic      [dac_decode_pkg::SAMPLE_W-1:0]   word_out      // Captured word
);
  logic [dac_decode_pkg::SAMPLE_W-1:0] word_reg;  // Holding register

  // Capture the whole word every rising edge
  // Synchroniser is deliberately absent: the source is timed to this clock
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      word_reg <= dac_decode_pkg::ZERO_WORD;
    end else begin
      word_reg <= word_in;
    end
  end

  assign word_out = word_reg;
endmodule // sample_latch

/* core/therm_decoder.sv */
// Purpose: Binary to thermometer decoder for one segment field
// Assumes: SEGS equals 2**IN_W - 1
// Notes:   Purely combinational, registered by the caller
`timescale 1ns/1ps
module therm_decoder #(
  parameter int IN_W = 5,   // Field width
  parameter int SEGS = 31   // Segment count
) (
  input  wire logic [IN_W-1:0] value_in,   // Field value
  output logic      [SEGS-1:0] therm_out   // Lowest value_in bits set
);
  // Segment k on when value exceeds k, so count of ones equals value
  always_comb begin
    for (int k = 0; k < SEGS; k++) begin
      therm_out[k] = (32'(value_in) > k);
    end
  end
endmodule // therm_decoder

/* verification/sample_source.sv */
// Purpose: Behavioural digital sample source feeding the parallel data pins
// Assumes: The bench changes word_in only on the falling edge of the sample clock
// Notes:   Pins follow word_in directly, so the word is stable around every rising edge
`timescale 1ns/1ps
module sample_source (
  input  wire logic [dac_decode_pkg::SAMPLE_W-1:0] word_in,             // Word to present
  output logic                                     sample_bit_top,      // Bit 11, most significant
  output logic      [dac_decode_pkg::SAMPLE_W-3:0] sample_bits_middle,  // Bits 10 down to 1
  output logic                                     sample_bit_bottom    // Bit 0, least significant
);
  ////////////////////////////////////////////////////////////////////////////
  // Bit order: top pin takes the heaviest bit, bottom pin the lightest
  assign sample_bit_top     = word_in[11];
  assign sample_bits_middle = word_in[10:1];
  assign sample_bit_bottom  = word_in[0];
endmodule // sample_source

/* verification/tb.sv */
// Purpose: Self-checking bench for the segmented DAC input decoder
// Assumes: Two edges of data latency, three edges after a mode or power change
// Notes:   Random words from a fixed seed, with extreme codes among them
`timescale 1ns/1ps
module tb;
  logic                          sys_clk_in = 1'b0;  // Sample clock, 100 ns
  logic                          rst_b_in;           // Async reset, low
  logic                          format_twos_in;     // Data format select
  logic                          power_down_in;      // Power-down request
  logic [11:0]                   word;               // Word the source presents
  logic [11:0]                   w1;                 // Word captured at last edge
  logic [11:0]                   w2;                 // Word captured one edge earlier
  logic                          top_bit;            // Source pin, bit 11
  logic [9:0]                    mid_bits;           // Source pins, bits 10..1
  logic                          low_bit;            // Source pin, bit 0
  dac_decode_pkg::switch_drive_t drive;              // Switch controls seen
  logic [11:0]                   code;               // Effective code seen
  logic [11:0]                   ccode;              // Complement code seen
  logic                          pd_out;             // Power-down state seen
  integer                        seed;               // Random seed
  integer                        miscompares;        // Mismatches
  integer                        n_checks;           // Comparisons made
  int                            settle;             // Steps to skip after a change
  logic [11:0] corners [6] = '{12'h000, 12'hfff, 12'h800, 12'h7ff, 12'h001, 12'h078};

  always #50 sys_clk_in = ~sys_clk_in;

  sample_source src (.word_in(word), .sample_bit_top(top_bit), .sample_bits_middle(mid_bits),
                     .sample_bit_bottom(low_bit));

  segmented_dac_input_decoder DUT (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .sample_bit_top(top_bit),
    .sample_bits_middle(mid_bits), .sample_bit_bottom(low_bit), .format_twos_in(format_twos_in),
    .power_down_in(power_down_in), .switch_drive_out(drive), .dac_code_out(code),
    .complement_code_out(ccode), .powered_down_out(pd_out));

  ////////////////////////////////////////////////////////////////////////////
  // Expected switch set: thermometer fields, binary tail, exact complement
  function automatic dac_decode_pkg::switch_drive_t exp_drive(input logic [11:0] c);
    exp_drive.to_primary.top_on = 31'((32'h1 << c[11:7]) - 32'h1);
    exp_drive.to_primary.mid_on = 15'((16'h1 << c[6:3]) - 16'h1);
    exp_drive.to_primary.low_on = c[2:0];
    exp_drive.to_complement     = ~exp_drive.to_primary;
  endfunction

  // Expected code from the word and the settled mode pins
  function automatic logic [11:0] exp_code(input logic [11:0] w);
    if (power_down_in) return 12'h000;
    return format_twos_in ? (w ^ 12'h800) : w;
  endfunction

  task automatic check(input logic [97:0] seen, input logic [97:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // One sample per clock: compare what left two edges ago, then present next
  task automatic step(input logic [11:0] w);
    logic [11:0] c;
    @(negedge sys_clk_in);
    c = exp_code(w2);
    if (settle == 0) begin
      check(98'(drive), 98'(exp_drive(c)), "switch drive");
      check(98'(code), 98'(c), "effective code");
      check(98'(ccode), 98'(12'(dac_decode_pkg::FULL_SCALE) - c), "complement code");
      check(98'(pd_out), 98'(power_down_in), "power-down state");
    end else begin
      settle--;
    end
    w2 = w1;
    w1 = w;
    word = w;
  endtask

  // Mode pins change with the data; outputs trusted again after the sync delay
  task automatic set_mode(input logic fmt, input logic pd);
    format_twos_in = fmt;
    power_down_in  = pd;
    settle         = 2;
  endtask

  // Guard against a hung run
  initial begin
    repeat (3000) @(posedge sys_clk_in);
    miscompares++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: binary, two's complement, power-down, mid-run reset
  initial begin
    seed = 32'h9b3cfb1a;
    word = 12'h000;
    w1 = 12'h000;
    w2 = 12'h000;
    miscompares = 0;
    n_checks = 0;
    format_twos_in = 1'b0;
    power_down_in = 1'b0;
    settle = 2;
    rst_b_in = 1'b0;
    repeat (2) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    rst_b_in = 1'b1;
    for (int m = 0; m < 3; m++) begin
      set_mode(m == 1, m == 2);
      for (int i = 0; i < 6; i++) step(corners[i]);
      repeat (40) step(12'($random(seed)));
    end
    set_mode(1'b0, 1'b0);
    repeat (8) step(12'($random(seed)));
    // Reset while streaming: all sources go to the complementary side
    rst_b_in = 1'b0;
    @(negedge sys_clk_in);
    check(98'(drive), 98'(exp_drive(12'h000)), "drive in reset");
    check(98'({code, ccode, pd_out}), 98'({12'h000, 12'hfff, 1'b0}), "codes in reset");
    rst_b_in = 1'b1;
    w1 = word;
    w2 = word;
    set_mode(1'b1, 1'b0);
    for (int i = 0; i < 6; i++) step(corners[i]);
    repeat (30) step(12'($random(seed)));
    finish_test();
  end
endmodule // tb
